// [hdl/sar_defs.svh]
// Constants for the sampling converter control and serial readout block.
// Assumes the block clock runs at the rate given by SAR_CLK_PERIOD_NS.
`ifndef SAR_DEFS_SVH
`define SAR_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SAR_CLK_PERIOD_NS 100
`define SAR_CONV_TIME_NS 8000
`define SAR_AUTO_TIME_NS 14000
// Longest times round down to whole cycles
`define SAR_CONV_CYCLES (`SAR_CONV_TIME_NS / `SAR_CLK_PERIOD_NS)
`define SAR_WAKE_CYCLES ((`SAR_AUTO_TIME_NS - `SAR_CONV_TIME_NS) / `SAR_CLK_PERIOD_NS)

// ----------------------------------------
// Frame layout and width of the conversion and wake counter
// ----------------------------------------
`define SAR_RESULT_BITS 12
`define SAR_LEAD_ZEROS 4
`define SAR_FRAME_BITS 16
`define SAR_CNT_WIDTH 8

`endif

// [hdl/sar_pkg.sv]
// Types shared by the converter control block.
// Assumes nothing beyond a SystemVerilog elaborator.
package sar_pkg;

  // ----------------------------------------
  // Control states, one-hot
  // ----------------------------------------
  typedef enum logic [3:0]
  {
    SAR_ST_IDLE = 4'b0001,
    SAR_ST_CONV = 4'b0010,
    SAR_ST_SLEEP = 4'b0100,
    SAR_ST_WAKE = 4'b1000
  } sar_state_t;

endpackage : sar_pkg

// [hdl/sar_sync.sv]
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes the caller reads only q.
`timescale 1ns/10ps
`default_nettype none

module sar_sync #(
  parameter int WIDTH = 1,
  // Reset to each pin's idle level, or a false edge follows reset
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : sar_sync

`default_nettype wire

// [hdl/sar_top.sv]
// Conversion control and serial readout of a 12-bit sampling converter.
// Assumes SAMPLE_CODE comes from the converter core on CLK; the start and
// serial clock pins are asynchronous and are synchronised here.
//
// Function
// - Start falling edge enters hold, starts conversion
// - Busy rises at start, falls when done
// - Start low at end enters power-down
// - Start rising edge wakes from power-down
// - New output bit on each of the first fifteen serial falling edges
// - Frame is four zeros then twelve bits
// - Sixteenth edge: hold bit, then float output
// - Result coded as straight binary
// - Conversion 8 us; auto sleep 14 us
`timescale 1ns/10ps
`default_nettype none
`include "sar_defs.svh"

module sar_top #(
  parameter int RESULT_BITS = `SAR_RESULT_BITS,
  parameter int FRAME_BITS = `SAR_FRAME_BITS
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CONV_START_N,
  input wire logic SCLK,
  input wire logic [RESULT_BITS-1:0] SAMPLE_CODE,
  output logic BUSY,
  output logic HOLD,
  output logic POWER_DOWN,
  output logic SERIAL_OUT,
  output logic SERIAL_OUT_OE
);

  localparam logic [`SAR_CNT_WIDTH-1:0] CONV_LAST = `SAR_CNT_WIDTH'(`SAR_CONV_CYCLES - 1);
  localparam logic [`SAR_CNT_WIDTH-1:0] WAKE_LAST = `SAR_CNT_WIDTH'(`SAR_WAKE_CYCLES - 1);
  localparam logic [4:0] BIT_LAST = 5'(FRAME_BITS - 1);

  // ----------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------
  logic [1:0] pins_sync;
  logic conv_lvl_prev;
  logic sclk_prev;

  sar_sync #(
    .WIDTH(2),
    .RESET_VAL(2'h2)
  ) u_sync (
    .clk(CLK),
    .resetn(RESETN),
    .d({CONV_START_N, SCLK}),
    .q(pins_sync)
  );

  wire conv_lvl = pins_sync[1];
  wire sclk_lvl = pins_sync[0];
  // Start pin edges start and wake; its level is read only at the end of conversion
  wire conv_fall = conv_lvl_prev & ~conv_lvl;
  wire conv_rise = ~conv_lvl_prev & conv_lvl;
  wire sclk_fall = sclk_prev & ~sclk_lvl;

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      conv_lvl_prev <= 1'b1;
      sclk_prev <= 1'b0;
    end
    else
    begin
      conv_lvl_prev <= conv_lvl;
      sclk_prev <= sclk_lvl;
    end
  end

  // ----------------------------------------
  // Conversion control
  // ----------------------------------------
  sar_pkg::sar_state_t state;
  logic [`SAR_CNT_WIDTH-1:0] cnt;
  logic pending;
  logic [RESULT_BITS-1:0] held_code;

  wire cnt_done = (cnt == '0);
  wire idle_start = (state == sar_pkg::SAR_ST_IDLE) && conv_fall;
  wire wake_start = (state == sar_pkg::SAR_ST_WAKE) && conv_fall && !pending;
  wire start = idle_start | wake_start;
  wire conv_end = (state == sar_pkg::SAR_ST_CONV) && cnt_done;

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      state <= sar_pkg::SAR_ST_IDLE;
      cnt <= '0;
      pending <= 1'b0;
      held_code <= '0;
      BUSY <= 1'b0;
      HOLD <= 1'b0;
      POWER_DOWN <= 1'b0;
    end
    else
    begin
      if (start)
      begin
        BUSY <= 1'b1;
        HOLD <= 1'b1;
        held_code <= SAMPLE_CODE;
      end
      case (state)
        sar_pkg::SAR_ST_IDLE:
        begin
          if (conv_fall)
          begin
            state <= sar_pkg::SAR_ST_CONV;
            cnt <= CONV_LAST;
          end
        end
        sar_pkg::SAR_ST_CONV:
        begin
          if (cnt_done)
          begin
            BUSY <= 1'b0;
            HOLD <= 1'b0;
            pending <= 1'b0;
            // Start still low here means the host asked for auto sleep
            if (!conv_lvl)
            begin
              state <= sar_pkg::SAR_ST_SLEEP;
              POWER_DOWN <= 1'b1;
            end
            else
            begin
              state <= sar_pkg::SAR_ST_IDLE;
            end
          end
          else
          begin
            cnt <= cnt - 1'b1;
          end
        end
        sar_pkg::SAR_ST_SLEEP:
        begin
          // A falling edge cannot occur here: the pin was low on entry
          if (conv_rise)
          begin
            state <= sar_pkg::SAR_ST_WAKE;
            POWER_DOWN <= 1'b0;
            cnt <= WAKE_LAST;
          end
        end
        sar_pkg::SAR_ST_WAKE:
        begin
          if (wake_start)
          begin
            pending <= 1'b1;
          end
          // A start seen while waking is converted once the wake time ends
          if (cnt_done)
          begin
            if (pending || wake_start)
            begin
              state <= sar_pkg::SAR_ST_CONV;
              cnt <= CONV_LAST;
            end
            else
            begin
              state <= sar_pkg::SAR_ST_IDLE;
            end
          end
          else
          begin
            cnt <= cnt - 1'b1;
          end
        end
        default:
        begin
          state <= sar_pkg::SAR_ST_IDLE;
          cnt <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Serial readout
  // ----------------------------------------
  logic [FRAME_BITS-1:0] shift;
  logic [4:0] bit_idx;

  wire [FRAME_BITS-1:0] frame_load = {{`SAR_LEAD_ZEROS{1'b0}}, held_code};
  wire last_edge = (bit_idx == BIT_LAST);

  assign SERIAL_OUT = shift[FRAME_BITS-1];

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      shift <= '0;
      bit_idx <= '0;
      SERIAL_OUT_OE <= 1'b0;
    end
    else if (conv_end)
    begin
      // Newest result wins over a read left unfinished
      shift <= frame_load;
      bit_idx <= '0;
      SERIAL_OUT_OE <= 1'b1;
    end
    else if (sclk_fall && SERIAL_OUT_OE)
    begin
      if (last_edge)
      begin
        // Data stays put; only the driver lets go
        SERIAL_OUT_OE <= 1'b0;
      end
      else
      begin
        // Synchroniser delay keeps the old bit valid past the edge
        shift <= {shift[FRAME_BITS-2:0], 1'b0};
        bit_idx <= bit_idx + 1'b1;
      end
    end
  end

endmodule : sar_top

`default_nettype wire

// [tb/sar_top_monitor.sv]
// Port checker for the converter control block.
// Assumes it is bound onto sar_top.
`timescale 1ns/10ps
`default_nettype none
module sar_top_monitor #(
  parameter int RESULT_BITS = 12
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CONV_START_N,
  input wire logic SCLK,
  input wire logic [RESULT_BITS-1:0] SAMPLE_CODE,
  input wire logic BUSY,
  input wire logic HOLD,
  input wire logic POWER_DOWN,
  input wire logic SERIAL_OUT,
  input wire logic SERIAL_OUT_OE
);
  logic [7:0] busy_len;
  logic [4:0] fall_cnt;
  logic sclk_d;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  always_ff @(posedge CLK)
  begin
    sclk_d <= SCLK;
    busy_len <= BUSY ? busy_len + 8'h01 : 8'h00;
    fall_cnt <= SERIAL_OUT_OE ? fall_cnt + 5'(sclk_d & ~SCLK) : 5'h00;
  end
  sequence conv_end;
    $fell(BUSY);
  endsequence
  AST_HOLD: assert property (HOLD == BUSY)
    else $error("hold differs from busy");
  AST_START: assert property ($fell(CONV_START_N) && !BUSY && !POWER_DOWN |-> ##[2:5] BUSY)
    else $error("busy late after start");
  // 80 cycles plain; up to 139 when the start lands early in wake-up
  AST_LEN: assert property (conv_end |-> busy_len >= 80 && busy_len <= 139)
    else $error("conversion length wrong");
  AST_LOAD: assert property (conv_end |-> SERIAL_OUT_OE && !SERIAL_OUT)
    else $error("frame not loaded");
  AST_SLEEP: assert property (conv_end ##0 (!$past(CONV_START_N, 3) && !CONV_START_N) |-> POWER_DOWN)
    else $error("no power down");
  AST_AWAKE: assert property (conv_end ##0 $past(CONV_START_N, 3) |-> !POWER_DOWN)
    else $error("power down without low start");
  AST_WAKE: assert property (POWER_DOWN && $rose(CONV_START_N) |-> ##[1:5] !POWER_DOWN)
    else $error("no wake up");
  AST_SHIFT: assert property ($changed(SERIAL_OUT) && !$fell(BUSY) |-> $past(SCLK, 5) && !$past(SCLK, 2))
    else $error("data moved without serial fall");
  AST_FLOAT: assert property ($fell(SERIAL_OUT_OE) |-> $stable(SERIAL_OUT) && fall_cnt == 16)
    else $error("float not after sixteen bits");
endmodule : sar_top_monitor
`default_nettype wire

// [tb/sar_host.sv]
// Host model: drives start and serial clock, reads frames.
// Assumes clk is the block clock; all changes follow its rising edge.
`timescale 1ns/10ps
`default_nettype none
module sar_host (
  input wire logic clk,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  output logic conv_start_n,
  output logic sclk
);
  logic line;
  // No pull on the line, so a floating output reads as garbage
  assign line = serial_out_oe ? serial_out : ~serial_out;
  initial
  begin
    conv_start_n = 1'b1;
    sclk = 1'b0;
  end
  task automatic set_start(input logic level);
    @(posedge clk);
    conv_start_n <= level;
  endtask : set_start
  // Called only between conversions
  task automatic read_frame(output logic [15:0] frame);
    for (int i = 0; i < 16; i++)
    begin
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      frame = {frame[14:0], line};
      sclk <= 1'b0;
    end
  endtask : read_frame
endmodule : sar_host
`default_nettype wire

// [tb/tb.sv]
// Testbench: conversions, sleep and wake, frame readout.
// Assumes the host model drives the start and serial clock pins.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] sample_code = 12'h000;
  logic conv_start_n, sclk, busy, hold, power_down, serial_out, serial_out_oe;
  int errors = 0;
  int checks_done = 0;
  always #50 clk = ~clk;
  sar_host u_sar_host (.clk(clk), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .conv_start_n(conv_start_n), .sclk(sclk));
  sar_top u_sar_top (.CLK(clk), .RESETN(resetn), .CONV_START_N(conv_start_n), .SCLK(sclk),
    .SAMPLE_CODE(sample_code), .BUSY(busy), .HOLD(hold), .POWER_DOWN(power_down),
    .SERIAL_OUT(serial_out), .SERIAL_OUT_OE(serial_out_oe));
  task automatic close_out;
    if (errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wait_for(ref logic sig, input logic level, output int n);
    n = 0;
    while (sig !== level)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 300)
      begin
        errors++;
        close_out();
      end
    end
  endtask : wait_for
  task automatic convert(input logic [11:0] code, input logic sleep);
    int n;
    logic [15:0] frame;
    @(posedge clk);
    sample_code <= code;
    u_sar_host.set_start(1'b0);
    wait_for(busy, 1'b1, n);
    check("busy_delay", 16'(n <= 5), 16'h0001);
    check("hold", 16'(hold), 16'h0001);
    if (!sleep)
      u_sar_host.set_start(1'b1);
    #1;
    wait_for(busy, 1'b0, n);
    // The high-sampling path spent one edge in set_start
    check("busy_len", sleep ? 16'(n) : 16'(n + 1), 16'h0050);
    check("power_down", 16'(power_down), 16'(sleep));
    if (sleep)
    begin
      u_sar_host.set_start(1'b1);
      #1;
      wait_for(power_down, 1'b0, n);
      check("wake_delay", 16'(n <= 5), 16'h0001);
      repeat (70) @(posedge clk);
    end
    u_sar_host.read_frame(frame);
    check("frame", frame, {4'h0, code});
    repeat (6) @(posedge clk);
    #1;
    check("oe_after_frame", 16'(serial_out_oe), 16'h0000);
  endtask : convert
  // A start during wake-up converts once the wake time has run out
  task automatic wake_convert(input logic [11:0] first, input logic [11:0] second);
    int n;
    logic [15:0] frame;
    @(posedge clk);
    sample_code <= first;
    u_sar_host.set_start(1'b0);
    wait_for(busy, 1'b1, n);
    wait_for(busy, 1'b0, n);
    check("sleep_entry", 16'(power_down), 16'h0001);
    u_sar_host.set_start(1'b1);
    sample_code <= second;
    #1;
    wait_for(power_down, 1'b0, n);
    u_sar_host.set_start(1'b0);
    repeat (3) @(posedge clk);
    u_sar_host.set_start(1'b1);
    #1;
    check("wake_busy", 16'(busy), 16'h0001);
    wait_for(busy, 1'b0, n);
    check("wake_conv_len", 16'(n + 5), 16'h008C);
    check("wake_power_down", 16'(power_down), 16'h0000);
    u_sar_host.read_frame(frame);
    check("wake_frame", frame, {4'h0, second});
  endtask : wake_convert
  initial
  begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    convert(12'h000, 1'b0);
    convert(12'hFFF, 1'b0);
    convert(12'hA5C, 1'b1);
    convert(12'h5A3, 1'b0);
    wake_convert(12'h3C1, 12'h96E);
    close_out();
  end
endmodule : tb
bind sar_top sar_top_monitor #(.RESULT_BITS(RESULT_BITS)) u_sar_top_monitor (.CLK(CLK),
  .RESETN(RESETN), .CONV_START_N(CONV_START_N), .SCLK(SCLK), .SAMPLE_CODE(SAMPLE_CODE),
  .BUSY(BUSY), .HOLD(HOLD), .POWER_DOWN(POWER_DOWN), .SERIAL_OUT(SERIAL_OUT),
  .SERIAL_OUT_OE(SERIAL_OUT_OE));
`default_nettype wire
